// *** verilog/bus_seq_pkg.sv ***
// Contract
// - Cacheable data load, multiple load or fetch miss runs as a four-word line fill.
// - Fill addresses are word aligned and ascend from the lowest word of the line.
// - A fill reads four aligned words and always fetches the boundary word first.
// - Requested fill word reaches cache and core together; later words stream while sequential.
// - Evicted line is written back only if region is write-back and line dirty.
// - Dirty eviction writes four ascending aligned words with four-word burst kind.
// - Atomic swap is one single read then one single write under bus lock.
// - Before an uncached swap, pending fills finish and the write buffer drains.
// - Uncached buffered swap locks the read and performs the write unbuffered.
// - Swap to a cacheable region is an ordinary data access with lock low.
// - In module test mode never master the bus; answer as slave when selected.
// - Abort ignored on buffered writes and fills; elsewhere it raises the abort exception (the code also ignores it on dirty evictions).
// - Simultaneous data and instruction misses: the data access runs and completes first.
// - Every other transfer drives the burst kind with the no-sequential-information code.
`default_nettype none
package bus_seq_pkg;
    // Burst kind codes
    localparam logic [1:0] BURST_NONE = 2'h0;
    localparam logic [1:0] BURST_FOUR = 2'h2;
    // Line geometry and address stepping
    localparam int LINE_BEATS = 4;
    localparam logic [31:0] ADDR_STEP = 32'h4;
    localparam logic [31:0] RESET_ADDR = 32'h0;
    // Sequencer states
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_FILL = 3'h1,
        S_EVICT = 3'h2,
        S_SINGLE = 3'h3,
        S_SWAP_RD = 3'h4,
        S_SWAP_WR = 3'h5,
        S_ACK = 3'h6
    } seq_state_t;
endpackage
`default_nettype wire

// *** verilog/beat_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Beat index handshake between the sequencer and its counter
interface beat_if #(parameter int W = 2);
    logic clear;
    logic adv;
    logic [W-1:0] idx;
    logic last;
    modport ctl (output clear, output adv, input idx, input last);
    modport cnt (input clear, input adv, output idx, output last);
endinterface
`default_nettype wire

// *** verilog/beat_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module beat_counter #(
    parameter int BEATS = 4
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    beat_if.cnt bc
);
    localparam int W = $clog2(BEATS);
    localparam logic [W-1:0] LAST_IDX = W'(BEATS - 1);

    typedef struct packed {
        logic [W-1:0] idx;
    } cnt_t;

    cnt_t s_q;
    cnt_t s_d;

    // Clear wins so a new burst always starts on the boundary word
    always_comb
    begin
        s_d = s_q;
        if (bc.clear)
        begin
            s_d.idx = '0;
        end
        else if (bc.adv)
        begin
            s_d.idx = s_q.idx + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign bc.idx = s_q.idx;
    assign bc.last = (s_q.idx == LAST_IDX);
endmodule
`default_nettype wire

// *** verilog/cache_bus_master_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module cache_bus_master_sequencer #(
    parameter int LINE_BEATS = bus_seq_pkg::LINE_BEATS
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic test_mode_i,
    input wire logic slave_select_i,
    input wire logic d_req_i,
    input wire logic d_write_i,
    input wire logic d_swap_i,
    input wire logic d_cacheable_i,
    input wire logic [31:0] d_addr_i,
    input wire logic [31:0] d_wdata_i,
    input wire logic i_req_i,
    input wire logic i_cacheable_i,
    input wire logic [31:0] i_addr_i,
    input wire logic core_seq_i,
    input wire logic evict_req_i,
    input wire logic evict_dirty_i,
    input wire logic evict_wb_region_i,
    input wire logic [31:0] evict_addr_i,
    input wire logic [LINE_BEATS*32-1:0] evict_line_i,
    input wire logic wbuf_valid_i,
    input wire logic [31:0] wbuf_addr_i,
    input wire logic [31:0] wbuf_data_i,
    input wire logic bus_gnt_i,
    input wire logic bus_done_i,
    input wire logic bus_abort_i,
    input wire logic [31:0] bus_rdata_i,
    output logic bus_req_o,
    output logic bus_valid_o,
    output logic bus_write_o,
    output logic bus_lock_o,
    output logic [1:0] bus_burst_o,
    output logic [31:0] bus_addr_o,
    output logic [31:0] bus_wdata_o,
    output logic [31:0] core_rdata_o,
    output logic d_done_o,
    output logic i_done_o,
    output logic stream_o,
    output logic fill_we_o,
    output logic fill_icache_o,
    output logic [$clog2(LINE_BEATS)-1:0] fill_idx_o,
    output logic evict_done_o,
    output logic wbuf_pop_o,
    output logic abort_o,
    output logic slave_ack_o
);
    localparam int IW = $clog2(LINE_BEATS);
    localparam int LW = LINE_BEATS * 32;
    localparam int LOB = IW + 2;

    typedef struct packed {
        bus_seq_pkg::seq_state_t state;
        logic req;
        logic valid;
        logic write;
        logic lock;
        logic [1:0] burst;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [LW-1:0] line;
        logic [IW-1:0] crit;
        logic instr;
        logic streaming;
        logic abort_ok;
        logic wbuf_op;
        logic [31:0] rdata;
        logic d_done;
        logic i_done;
        logic stream;
        logic fill_we;
        logic fill_icache;
        logic [IW-1:0] fill_idx;
        logic evict_done;
        logic wbuf_pop;
        logic abort;
        logic slave_ack;
    } seq_t;

    seq_t s_q;
    seq_t s_d;
    logic start;
    logic beat_end;
    logic [31:0] sel_addr;
    logic sel_cache;
    logic d_store;

    beat_if #(.W(IW)) bc_if ();

    beat_counter #(.BEATS(LINE_BEATS)) u_beats (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .bc(bc_if)
    );

    // Lowest byte address of the line holding a
    function automatic logic [31:0] line_base(input logic [31:0] a);
        return a & ~((32'h1 << LOB) - 32'h1);
    endfunction

    // One word of a captured line
    function automatic logic [31:0] line_word(input logic [LW-1:0] l, input logic [IW-1:0] i);
        return l[{i, 5'h00} +: 32];
    endfunction

    // Data side wins the pick when both caches miss together
    assign sel_addr = d_req_i ? d_addr_i : i_addr_i;
    assign sel_cache = d_req_i ? d_cacheable_i : i_cacheable_i;
    assign d_store = d_req_i && d_write_i && !d_swap_i;
    assign beat_end = s_q.valid && (bus_done_i || bus_abort_i);
    assign bc_if.clear = start;
    assign bc_if.adv = beat_end && (s_q.state inside {bus_seq_pkg::S_FILL, bus_seq_pkg::S_EVICT});

    // Sequencer next state; one bus operation at a time keeps ordering simple
    always_comb
    begin
        s_d = s_q;
        start = 1'b0;
        s_d.d_done = 1'b0;
        s_d.i_done = 1'b0;
        s_d.stream = 1'b0;
        s_d.fill_we = 1'b0;
        s_d.evict_done = 1'b0;
        s_d.wbuf_pop = 1'b0;
        s_d.abort = 1'b0;
        s_d.slave_ack = test_mode_i && slave_select_i;
        if (s_q.req && !s_q.valid && bus_gnt_i)
        begin
            s_d.valid = 1'b1;
        end
        unique case (s_q.state)
            bus_seq_pkg::S_IDLE:
            begin
                s_d.burst = bus_seq_pkg::BURST_NONE;
                s_d.wbuf_op = 1'b0;
                s_d.abort_ok = 1'b1;
                if (test_mode_i)
                begin
                    s_d.req = 1'b0;
                end
                else if (evict_req_i)
                begin
                    if (evict_dirty_i && evict_wb_region_i)
                    begin
                        s_d.state = bus_seq_pkg::S_EVICT;
                        s_d.req = 1'b1;
                        s_d.write = 1'b1;
                        s_d.abort_ok = 1'b0;
                        s_d.burst = bus_seq_pkg::BURST_FOUR;
                        s_d.addr = line_base(evict_addr_i);
                        s_d.line = evict_line_i;
                        s_d.wdata = line_word(evict_line_i, '0);
                        start = 1'b1;
                    end
                    else
                    begin
                        s_d.evict_done = 1'b1;
                        s_d.state = bus_seq_pkg::S_ACK;
                    end
                end
                else if (wbuf_valid_i)
                begin
                    // Buffered writes drain ahead of any new read
                    s_d.state = bus_seq_pkg::S_SINGLE;
                    s_d.req = 1'b1;
                    s_d.write = 1'b1;
                    s_d.wbuf_op = 1'b1;
                    s_d.abort_ok = 1'b0;
                    s_d.addr = {wbuf_addr_i[31:2], 2'h0};
                    s_d.wdata = wbuf_data_i;
                end
                else if (d_req_i || i_req_i)
                begin
                    s_d.req = 1'b1;
                    s_d.instr = !d_req_i;
                    s_d.write = d_store;
                    s_d.wdata = d_wdata_i;
                    s_d.addr = {sel_addr[31:2], 2'h0};
                    s_d.state = bus_seq_pkg::S_SINGLE;
                    if (sel_cache && !d_store)
                    begin
                        // Cacheable swap lands here too and keeps the lock low
                        s_d.state = bus_seq_pkg::S_FILL;
                        s_d.burst = bus_seq_pkg::BURST_FOUR;
                        s_d.addr = line_base(sel_addr);
                        s_d.crit = sel_addr[LOB-1:2];
                        s_d.abort_ok = 1'b0;
                        s_d.streaming = 1'b0;
                        start = 1'b1;
                    end
                    else if (d_req_i && d_swap_i)
                    begin
                        // Reached only with the write buffer empty
                        s_d.state = bus_seq_pkg::S_SWAP_RD;
                        s_d.lock = 1'b1;
                    end
                end
            end
            bus_seq_pkg::S_FILL:
            begin
                if (beat_end)
                begin
                    s_d.fill_we = 1'b1;
                    s_d.fill_icache = s_q.instr;
                    s_d.fill_idx = bc_if.idx;
                    s_d.rdata = bus_rdata_i;
                    if (bc_if.idx == s_q.crit)
                    begin
                        s_d.d_done = !s_q.instr;
                        s_d.i_done = s_q.instr;
                        s_d.streaming = 1'b1;
                    end
                    else
                    begin
                        // Streaming stops for good once the core leaves the line
                        s_d.stream = s_q.streaming && core_seq_i;
                        s_d.streaming = s_q.streaming && core_seq_i;
                    end
                    if (bc_if.last)
                    begin
                        s_d.valid = 1'b0;
                        s_d.req = 1'b0;
                        s_d.burst = bus_seq_pkg::BURST_NONE;
                        s_d.state = bus_seq_pkg::S_ACK;
                    end
                    else
                    begin
                        s_d.addr = s_q.addr + bus_seq_pkg::ADDR_STEP;
                    end
                end
            end
            bus_seq_pkg::S_EVICT:
            begin
                if (beat_end)
                begin
                    if (bc_if.last)
                    begin
                        s_d.evict_done = 1'b1;
                        s_d.valid = 1'b0;
                        s_d.req = 1'b0;
                        s_d.write = 1'b0;
                        s_d.burst = bus_seq_pkg::BURST_NONE;
                        s_d.state = bus_seq_pkg::S_ACK;
                    end
                    else
                    begin
                        s_d.addr = s_q.addr + bus_seq_pkg::ADDR_STEP;
                        s_d.wdata = line_word(s_q.line, IW'(bc_if.idx + 1'b1));
                    end
                end
            end
            bus_seq_pkg::S_SINGLE:
            begin
                if (beat_end)
                begin
                    s_d.rdata = bus_rdata_i;
                    s_d.wbuf_pop = s_q.wbuf_op;
                    s_d.d_done = !s_q.wbuf_op && !s_q.instr;
                    s_d.i_done = !s_q.wbuf_op && s_q.instr;
                    s_d.abort = bus_abort_i && s_q.abort_ok;
                    s_d.valid = 1'b0;
                    s_d.req = 1'b0;
                    s_d.write = 1'b0;
                    s_d.state = bus_seq_pkg::S_ACK;
                end
            end
            bus_seq_pkg::S_SWAP_RD:
            begin
                if (beat_end)
                begin
                    s_d.rdata = bus_rdata_i;
                    if (bus_abort_i)
                    begin
                        // No write after a failed read; drop the lock at once
                        s_d.abort = 1'b1;
                        s_d.d_done = 1'b1;
                        s_d.lock = 1'b0;
                        s_d.valid = 1'b0;
                        s_d.req = 1'b0;
                        s_d.state = bus_seq_pkg::S_ACK;
                    end
                    else
                    begin
                        // Valid stays up so the write follows with no gap
                        s_d.write = 1'b1;
                        s_d.state = bus_seq_pkg::S_SWAP_WR;
                    end
                end
            end
            bus_seq_pkg::S_SWAP_WR:
            begin
                if (beat_end)
                begin
                    s_d.abort = bus_abort_i;
                    s_d.d_done = 1'b1;
                    s_d.lock = 1'b0;
                    s_d.valid = 1'b0;
                    s_d.req = 1'b0;
                    s_d.write = 1'b0;
                    s_d.state = bus_seq_pkg::S_ACK;
                end
            end
            bus_seq_pkg::S_ACK:
            begin
                // One quiet cycle lets the requester drop its request
                s_d.state = bus_seq_pkg::S_IDLE;
            end
            default:
            begin
                s_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Every output straight from the state register
    assign bus_req_o = s_q.req;
    assign bus_valid_o = s_q.valid;
    assign bus_write_o = s_q.write;
    assign bus_lock_o = s_q.lock;
    assign bus_burst_o = s_q.burst;
    assign bus_addr_o = s_q.addr;
    assign bus_wdata_o = s_q.wdata;
    assign core_rdata_o = s_q.rdata;
    assign d_done_o = s_q.d_done;
    assign i_done_o = s_q.i_done;
    assign stream_o = s_q.stream;
    assign fill_we_o = s_q.fill_we;
    assign fill_icache_o = s_q.fill_icache;
    assign fill_idx_o = s_q.fill_idx;
    assign evict_done_o = s_q.evict_done;
    assign wbuf_pop_o = s_q.wbuf_pop;
    assign abort_o = s_q.abort;
    assign slave_ack_o = s_q.slave_ack;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    fill_burst_kind_a: assert property (s_q.state == bus_seq_pkg::S_FILL |->
        bus_burst_o == bus_seq_pkg::BURST_FOUR && !bus_write_o)
        else $error("fill without four-word burst kind");
    fill_ascend_a: assert property (s_q.state == bus_seq_pkg::S_FILL && beat_end
        && !bc_if.last |=> bus_addr_o == $past(bus_addr_o) + bus_seq_pkg::ADDR_STEP)
        else $error("fill address did not step up one word");
    fill_first_word_a: assert property (s_q.state == bus_seq_pkg::S_IDLE
        && s_d.state == bus_seq_pkg::S_FILL |=> bus_addr_o[LOB-1:0] == '0)
        else $error("fill did not start on line boundary");
    crit_word_a: assert property (fill_we_o && fill_idx_o == s_q.crit
        |-> (d_done_o || i_done_o) && s_q.streaming)
        else $error("requested fill word not passed to core");
    clean_drop_a: assert property (s_q.state == bus_seq_pkg::S_IDLE && !test_mode_i
        && evict_req_i && !(evict_dirty_i && evict_wb_region_i)
        |=> evict_done_o && !bus_req_o ##1 !bus_req_o)
        else $error("clean line caused a bus write");
    evict_burst_a: assert property (s_q.state == bus_seq_pkg::S_EVICT |->
        bus_write_o && bus_burst_o == bus_seq_pkg::BURST_FOUR)
        else $error("eviction not a four-word write");
    swap_pair_a: assert property (s_q.state == bus_seq_pkg::S_SWAP_RD && beat_end
        && !bus_abort_i |=> bus_lock_o && bus_write_o && bus_valid_o)
        else $error("swap write not locked to read");
    swap_drained_a: assert property (s_d.state == bus_seq_pkg::S_SWAP_RD
        && s_q.state == bus_seq_pkg::S_IDLE |-> !wbuf_valid_i)
        else $error("swap started with write buffer pending");
    lock_scope_a: assert property (bus_lock_o |-> s_q.state inside
        {bus_seq_pkg::S_SWAP_RD, bus_seq_pkg::S_SWAP_WR})
        else $error("lock raised outside uncached swap");
    test_slave_a: assert property (test_mode_i && slave_select_i
        |=> slave_ack_o)
        else $error("selected slave did not answer");
    abort_ignore_a: assert property (beat_end && !s_q.abort_ok |=> !abort_o)
        else $error("abort taken on fill or buffered write");
    data_first_a: assert property (s_q.state == bus_seq_pkg::S_IDLE && !test_mode_i
        && !evict_req_i && !wbuf_valid_i && d_req_i && i_req_i |=> !s_q.instr)
        else $error("instruction miss served before data miss");
    single_burst_a: assert property (s_q.state inside {bus_seq_pkg::S_SINGLE,
        bus_seq_pkg::S_SWAP_RD, bus_seq_pkg::S_SWAP_WR} |-> bus_burst_o == bus_seq_pkg::BURST_NONE)
        else $error("single transfer carries burst kind");
    lock_release_a: assert property (s_q.state == bus_seq_pkg::S_SWAP_WR && beat_end
        |=> !bus_lock_o)
        else $error("lock held after swap write");

    fill_seen_c: cover property (fill_we_o && fill_idx_o == '1);
    evict_seen_c: cover property (evict_done_o && $past(s_q.state) == bus_seq_pkg::S_EVICT);
    swap_seen_c: cover property (s_q.state == bus_seq_pkg::S_SWAP_WR && beat_end);
    stream_seen_c: cover property (stream_o);
endmodule
`default_nettype wire

// *** verif/bus_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// Arbiter plus memory slave on the far side of the sequencer
module bus_partner (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [3:0] lat_i,
    input wire logic abort_en_i,
    input wire logic bus_req_i,
    input wire logic bus_valid_i,
    input wire logic [31:0] bus_addr_i,
    output logic bus_gnt_o,
    output logic bus_done_o,
    output logic bus_abort_o,
    output logic [31:0] bus_rdata_o
);
    logic [3:0] wait_q;
    logic beat_end;
    // Only master here; grant held while locked, so nobody splits a swap
    assign bus_gnt_o = bus_req_i;
    assign beat_end = bus_valid_i && (wait_q >= lat_i);
    assign bus_done_o = beat_end && !abort_en_i;
    assign bus_abort_o = beat_end && abort_en_i;
    // Inverse outside done, so stale data never passes for a match
    assign bus_rdata_o = bus_addr_i ^ 32'hC3C3_0000 ^ {32{!bus_done_o}};
    // Wait states counted per beat
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            wait_q <= 4'h0;
        else if (!bus_valid_i || beat_end)
            wait_q <= 4'h0;
        else
            wait_q <= wait_q + 4'h1;
    end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // Flags: wr sw cch dirty wb seq ab, msb first
    typedef struct packed {
        logic [1:0] kind;
        logic [6:0] fl;
        logic [3:0] lat;
        logic [31:0] addr;
        logic [2:0] nb;
        logic [1:0] burst;
        logic lock;
        logic [1:0] nstr;
        logic nab;
    } row_t;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic lock;
        logic [1:0] burst;
    } beat_t;
    logic clk, nrst, test_mode, sel, d_req, d_write, d_swap, d_cch, i_req, i_cch, core_seq;
    logic ev_req, ev_dirty, ev_wb, wb_valid, abort_en, fside;
    logic [31:0] d_addr, d_wdata, i_addr, ev_addr, wb_addr, wb_data;
    logic [3:0] lat;
    wire logic gnt, b_done, b_abort, bus_req, bus_valid, bus_write, bus_lock, d_done, i_done;
    wire logic stream, fill_we, evict_done, wbuf_pop, abrt, slave_ack, fill_ic;
    wire logic [1:0] bus_burst, fill_idx;
    wire logic [31:0] rdata, bus_addr, bus_wdata, core_rdata;
    beat_t beats[$];
    logic [31:0] rd[$];
    int n_str, n_ab, n_fill, n_errors, n_tests;
    row_t rows[12] = '{
        '{2'h0, 7'h12, 4'h0, 32'h0108, 3'h4, 2'h2, 1'b0, 2'h1, 1'b0},
        '{2'h1, 7'h12, 4'h2, 32'h0204, 3'h4, 2'h2, 1'b0, 2'h2, 1'b0},
        '{2'h0, 7'h00, 4'h1, 32'h0308, 3'h1, 2'h0, 1'b0, 2'h0, 1'b0},
        '{2'h0, 7'h40, 4'h0, 32'h0400, 3'h1, 2'h0, 1'b0, 2'h0, 1'b0},
        '{2'h0, 7'h20, 4'h2, 32'h0500, 3'h2, 2'h0, 1'b1, 2'h0, 1'b0},
        '{2'h0, 7'h30, 4'h0, 32'h0608, 3'h4, 2'h2, 1'b0, 2'h0, 1'b0},
        '{2'h2, 7'h0C, 4'h1, 32'h0704, 3'h4, 2'h2, 1'b0, 2'h0, 1'b0},
        '{2'h2, 7'h04, 4'h0, 32'h0804, 3'h0, 2'h0, 1'b0, 2'h0, 1'b0},
        '{2'h2, 7'h08, 4'h0, 32'h0904, 3'h0, 2'h0, 1'b0, 2'h0, 1'b0},
        '{2'h0, 7'h01, 4'h0, 32'h0A00, 3'h1, 2'h0, 1'b0, 2'h0, 1'b1},
        '{2'h0, 7'h11, 4'h0, 32'h0B00, 3'h4, 2'h2, 1'b0, 2'h0, 1'b0},
        '{2'h2, 7'h0D, 4'h0, 32'h0C00, 3'h4, 2'h2, 1'b0, 2'h0, 1'b0}};

    cache_bus_master_sequencer cache_bus_master_sequencer_i (
        .clk_sys_i(clk), .nrst_i(nrst), .test_mode_i(test_mode), .slave_select_i(sel),
        .d_req_i(d_req), .d_write_i(d_write), .d_swap_i(d_swap), .d_cacheable_i(d_cch),
        .d_addr_i(d_addr), .d_wdata_i(d_wdata), .i_req_i(i_req), .i_cacheable_i(i_cch),
        .i_addr_i(i_addr), .core_seq_i(core_seq), .evict_req_i(ev_req),
        .evict_dirty_i(ev_dirty), .evict_wb_region_i(ev_wb), .evict_addr_i(ev_addr),
        .evict_line_i({32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111}),
        .wbuf_valid_i(wb_valid), .wbuf_addr_i(wb_addr), .wbuf_data_i(wb_data),
        .bus_gnt_i(gnt), .bus_done_i(b_done), .bus_abort_i(b_abort), .bus_rdata_i(rdata),
        .bus_req_o(bus_req), .bus_valid_o(bus_valid), .bus_write_o(bus_write),
        .bus_lock_o(bus_lock), .bus_burst_o(bus_burst), .bus_addr_o(bus_addr),
        .bus_wdata_o(bus_wdata), .core_rdata_o(core_rdata), .d_done_o(d_done),
        .i_done_o(i_done), .stream_o(stream), .fill_we_o(fill_we), .fill_icache_o(fill_ic),
        .fill_idx_o(fill_idx), .evict_done_o(evict_done), .wbuf_pop_o(wbuf_pop),
        .abort_o(abrt), .slave_ack_o(slave_ack));
    bus_partner bus_partner_i (
        .clk_sys_i(clk), .nrst_i(nrst), .lat_i(lat), .abort_en_i(abort_en),
        .bus_req_i(bus_req), .bus_valid_i(bus_valid), .bus_addr_i(bus_addr),
        .bus_gnt_o(gnt), .bus_done_o(b_done), .bus_abort_o(b_abort), .bus_rdata_o(rdata));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Bus beats and core-side pulses as the design drives them
    always @(posedge clk)
    begin
        if (bus_valid === 1'b1 && (b_done | b_abort) === 1'b1)
            beats.push_back({bus_addr, bus_wdata, bus_write, bus_lock, bus_burst});
        if (stream === 1'b1)
            n_str++;
        if (abrt === 1'b1)
            n_ab++;
        if ((d_done | i_done) === 1'b1)
            rd.push_back(core_rdata);
        if (fill_we === 1'b1)
        begin
            check("fill idx", fill_idx, n_fill[1:0]);
            check("fill side", fill_ic, fside ^ n_fill[2]);
            n_fill++;
        end
    end
    // Waits for a completion pulse, then drops the matching request
    task automatic wait_pulse;
        int k;
        logic dn, inn, en;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
            dn = d_done | abrt;
            inn = i_done;
            en = evict_done;
        end
        while ((dn | inn | en) !== 1'b1 && k < 200);
        check("pulse wait", k < 200, 1'b1);
        #1;
        if (dn === 1'b1)
            d_req = 1'b0;
        if (inn === 1'b1)
            i_req = 1'b0;
        if (en === 1'b1)
            ev_req = 1'b0;
    endtask
    task automatic wait_idle;
        int k;
        k = 0;
        while (bus_req !== 1'b0 && k < 200)
        begin
            @(posedge clk);
            k++;
        end
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic start(input logic [31:0] da, input logic sw, input logic cch);
        beats.delete();
        rd.delete();
        {n_str, n_ab, n_fill} = '0;
        d_addr = da;
        d_wdata = da ^ 32'h5A5A_5A5A;
        d_swap = sw;
        d_cch = cch;
        i_cch = cch;
    endtask
    task automatic run_row(input row_t r);
        logic [31:0] base;
        start(r.addr, r.fl[5], r.fl[4]);
        {d_write, ev_dirty, ev_wb, core_seq, abort_en} = {r.fl[6], r.fl[3:0]};
        {lat, i_addr, ev_addr, fside} = {r.lat, r.addr, r.addr, r.kind == 2'h1};
        {d_req, i_req, ev_req} = {r.kind == 2'h0, r.kind == 2'h1, r.kind == 2'h2};
        wait_pulse();
        wait_idle();
        check("beats", beats.size(), r.nb);
        base = (r.nb == 3'h4) ? {r.addr[31:4], 4'h0} : r.addr;
        for (int b = 0; b < beats.size(); b++)
        begin
            check("addr", beats[b].addr, (r.nb == 3'h2) ? base : base + 32'(4 * b));
            check("burst", beats[b].burst, r.burst);
            check("lock", beats[b].lock, r.lock);
            check("write", beats[b].wr, r.kind == 2'h2 || r.fl[6:5] == 2'h2 || r.nb == 3'h2 && b == 1);
            if (beats[b].wr === 1'b1)
                check("wdata", beats[b].wdata, r.kind == 2'h2 ? 32'(32'h1111_1111 * (b + 1)) : d_wdata);
        end
        if (r.kind != 2'h2 && !r.fl[6] && !r.fl[0])
            check("rdata", rd[0], r.addr ^ 32'hC3C3_0000);
        check("streams", n_str, r.nstr);
        check("aborts", n_ab, r.nab);
        check("fills", n_fill, (r.nb == 3'h4 && r.kind != 2'h2) ? 4 : 0);
        check("lock idle", bus_lock, 1'b0);
    endtask
    // Watchdog sized well beyond the expected run
    initial
    begin
        #400000;
        n_errors++;
        wrap_up();
    end
    initial
    begin
        {nrst, test_mode, sel, d_req, d_write, d_swap, d_cch, i_req, i_cch} = 9'h0;
        {core_seq, ev_req, ev_dirty, ev_wb, wb_valid, abort_en, fside, lat} = 11'h0;
        {d_addr, d_wdata, i_addr, ev_addr, wb_addr, wb_data} = 192'h0;
        n_errors = 0;
        n_tests = 0;
        repeat (8) @(posedge clk);
        check("reset out", {bus_req, bus_valid, bus_lock, bus_burst, bus_addr[26:0]}, 32'h0);
        #1;
        nrst = 1'b1;
        foreach (rows[i])
            run_row(rows[i]);
        // Both caches miss together: data line goes first
        start(32'h0D00, 1'b0, 1'b1);
        {abort_en, lat, d_write, i_addr, fside} = {1'b0, 4'h0, 1'b0, 32'h0E00, 1'b0};
        {d_req, i_req} = 2'h3;
        wait_pulse();
        wait_pulse();
        wait_idle();
        check("order", beats[0].addr, 32'h0D00);
        check("order", beats[4].addr, 32'h0E00);
        // Swap behind a buffered write: buffer drains before the locked read
        start(32'h1000, 1'b1, 1'b0);
        {wb_valid, wb_addr, wb_data} = {1'b1, 32'h0F00, 32'h0BAD_F00D};
        d_req = 1'b1;
        @(posedge clk iff (wbuf_pop === 1'b1)) #1 wb_valid = 1'b0; // Entry leaves on pop
        wait_pulse();
        wait_idle();
        check("drain", {beats[0].addr[15:0], beats[0].lock, beats[1].lock}, 32'h3C01);
        check("drain data", beats[0].wdata, 32'h0BAD_F00D);
        // Slave-only mode: selected, never masters the bus
        {test_mode, sel, d_req} = 3'h7;
        repeat (4) @(posedge clk);
        check("slave ack", {slave_ack, bus_req}, 2'h2);
        #1;
        sel = 1'b0;
        repeat (2) @(posedge clk);
        check("slave idle", {slave_ack, bus_req}, 2'h0);
        #1;
        {test_mode, d_req} = 2'h0;
        wait_idle();
        wrap_up();
    end
endmodule
`default_nettype wire
